/* verilog/fass_pkg.sv */
// Shared constants, types and helpers for the flash access and clock select ends
`default_nettype none
package fass_pkg;
	// Array geometry; the read address is {cacheable, module, word}
	localparam int MODULES = 5;
	localparam int WORDS = 16;
	localparam int MOD_W = 3;
	localparam int WORD_W = 4;
	localparam int ADDR_W = 1 + MOD_W + WORD_W;
	localparam int DATA_W = 32;
	localparam int WAIT_W = 3;
	localparam int EXT_W = 2;
	localparam int STALL_W = 4;
	localparam int DIV_W = 10;
	localparam int PE_CNT_W = 21;
	// Module that may be changed while any other module is read
	localparam logic [MOD_W-1:0] FREE_MODULE = 3'h4;
	// Parallel program/erase limits by read activity
	localparam logic [2:0] PAR_PE_MAX = 3'h5;
	localparam logic [2:0] PAR_PE_CONTENDED = 3'h1;
	// Clock source codes
	localparam logic [1:0] CLKSRC_PRESCALE = 2'h2;
	localparam logic [1:0] CLKSRC_DIRECT = 2'h3;
	// Program/erase timing, longest times in ns at a 5 ns clock
	localparam int CLK_PERIOD_NS = 5;
	localparam int PROG_TIME_NS = 3500000;
	localparam int ERASE_TIME_NS = 8000000;
	localparam int PE_OVERHEAD_CYCLES = 4;
	localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS - PE_OVERHEAD_CYCLES;
	localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS - PE_OVERHEAD_CYCLES;
	// Frequency limits for wait settings, MHz
	localparam int WS1_MAX_MHZ = 8;
	localparam int WS2_MAX_MHZ = 13;
	localparam int WS3_MAX_MHZ = 17;
	localparam int EXT0_MAX_MHZ = 80;
	// Wait settings after reset and the safe set
	localparam logic [WAIT_W-1:0] WAIT_RST = 3'h1;
	localparam logic [EXT_W-1:0] EXT_RST = 2'h0;
	localparam logic [WAIT_W-1:0] WAIT_SAFE = 3'h4;
	localparam logic [EXT_W-1:0] EXT_SAFE = 2'h1;
	// Register map, byte offsets
	localparam int AXI_ADDR_W = 12;
	localparam logic [AXI_ADDR_W-1:0] REG_BUS_CTRL = 12'h000;
	localparam logic [AXI_ADDR_W-1:0] REG_STARTUP = 12'h004;
	localparam logic [AXI_ADDR_W-1:0] REG_CLK_CTRL = 12'h008;
	localparam logic [AXI_ADDR_W-1:0] REG_PE_CMD = 12'h00c;
	localparam logic [AXI_ADDR_W-1:0] REG_PE_DATA = 12'h010;
	localparam logic [AXI_ADDR_W-1:0] REG_READ_ADDR = 12'h014;
	localparam logic [AXI_ADDR_W-1:0] REG_READ_DATA = 12'h018;
	localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 12'h01c;
	// Field positions
	localparam int EXT_POS = 4;
	localparam int APP_RESET_POS = 1;
	localparam int VCO_BYPASS_POS = 2;
	localparam int DIV_POS = 16;
	localparam int PE_ERASE_POS = 8;
	localparam int PE_WORD_POS = 12;
	localparam int PE_GO_POS = 31;
	localparam int ST_RD_DONE = 8;
	localparam int ST_RD_ERR = 9;
	localparam int ST_PE_REJ = 10;
	localparam int ST_PE_DONE = 11;
	localparam int ST_RD_PEND = 12;
	localparam int ST_PE_PEND = 13;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {RD_IDLE = 1'b0, RD_WAIT = 1'b1} fass_rd_t;

	// Least wait count for a system clock frequency
	function automatic logic [WAIT_W-1:0] fass_min_wait(input int mhz);
		if (mhz <= WS1_MAX_MHZ) return WAIT_W'(1);
		if (mhz <= WS2_MAX_MHZ) return WAIT_W'(2);
		if (mhz <= WS3_MAX_MHZ) return WAIT_W'(3);
		return WAIT_W'(4);
	endfunction : fass_min_wait

	// Least wait extension for a system clock frequency
	function automatic logic [EXT_W-1:0] fass_min_ext(input int mhz);
		return (mhz <= EXT0_MAX_MHZ) ? EXT_W'(0) : EXT_W'(1);
	endfunction : fass_min_ext

	function automatic logic [2:0] fass_ones(input logic [MODULES-1:0] v);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < MODULES; i++) begin
			c = c + {2'h0, v[i]};
		end
		return c;
	endfunction : fass_ones
endpackage : fass_pkg
`default_nettype wire

/* verilog/fass_if.sv */
// Link between the fetch/command end and the flash array end
`timescale 1ns/1ps
`default_nettype none
interface fass_if
	import fass_pkg::*;
();
	logic rdReq;
	logic [ADDR_W-1:0] rdAddr;
	logic rdValid;
	logic rdError;
	logic [DATA_W-1:0] rdData;
	logic [WAIT_W-1:0] flashWaitCount;
	logic [EXT_W-1:0] flashWaitExtension;
	logic peStart;
	logic peErase;
	logic [MODULES-1:0] peMask;
	logic [WORD_W-1:0] peWord;
	logic [DATA_W-1:0] peData;
	logic peAccept;
	logic peReject;
	logic peDone;
	logic [MODULES-1:0] peBusy;
	logic [1:0] clockSourceSelect;
	logic vcoBypass;
	logic [DIV_W-1:0] outputDividerValue;

	modport device (
		input rdReq, rdAddr, flashWaitCount, flashWaitExtension,
		input peStart, peErase, peMask, peWord, peData,
		input clockSourceSelect, vcoBypass, outputDividerValue,
		output rdValid, rdError, rdData, peAccept, peReject, peDone, peBusy
	);
	modport host (
		output rdReq, rdAddr, flashWaitCount, flashWaitExtension,
		output peStart, peErase, peMask, peWord, peData,
		output clockSourceSelect, vcoBypass, outputDividerValue,
		input rdValid, rdError, rdData, peAccept, peReject, peDone, peBusy
	);
endinterface : fass_if
`default_nettype wire

/* verilog/fass_device.sv */
// Flash array end: wait-state reads, program/erase sequencing, system clock select
// Functional notes
// - Wait count follows system clock frequency.
// - Wait extension one above 80 MHz.
// - Cacheable miss adds one; hit none.
// - Waits only on non-sequential reads; here a sequential read still waits for what is left of the prefetch.
// - Never change the module being read.
// - Five parallel, one if reads spread.
// - Module four changeable while others read.
// - Program 3.5 ms, erase 8.0 ms max.
// - Few extra cycles on each operation.
// - Erased, unprotected contents after reset.
// - Code 11 passes direct clock input.
// - Code 10 with bypass uses divider.
// - Divide oscillator by value plus one.
// - Factor one passes oscillator unchanged.
// - Safe wait set before exceeding 80 MHz.
`timescale 1ns/1ps
`default_nettype none
module fass_device
	import fass_pkg::*;
#(
	parameter int PROG_RUN = PROG_CYCLES,
	parameter int ERASE_RUN = ERASE_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	fass_if.device link,
	input wire logic directClockInput,
	input wire logic crystalInput,
	output logic sysClockOut,
	output logic [MODULES-1:0] moduleBusy
);
	typedef struct packed {
		fass_rd_t rd;
		logic [STALL_W-1:0] stall;
		logic [STALL_W-1:0] prefetch;
		logic [ADDR_W-1:0] curAddr;
		logic lastValid;
		logic [MOD_W-1:0] lastModule;
		logic [WORD_W-1:0] lastWord;
		logic cacheValid;
		logic [MOD_W+WORD_W-1:0] cacheTag;
		logic [DATA_W-1:0] cacheData;
		logic rdValid;
		logic rdError;
		logic [DATA_W-1:0] rdData;
		logic [MODULES-1:0] peBusy;
		logic peErase;
		logic [WORD_W-1:0] peWord;
		logic [DATA_W-1:0] peData;
		logic [PE_CNT_W-1:0] peCnt;
		logic peAccept;
		logic peReject;
		logic peDone;
		logic [MODULES-1:0][WORDS-1:0][DATA_W-1:0] mem;
		logic oscPrev;
		logic [DIV_W-1:0] divCnt;
		logic sysClk;
	} fass_dev_state_t;

	fass_dev_state_t s;
	fass_dev_state_t n;

	// Next state of the whole end
	always_comb begin
		logic [MOD_W-1:0] reqMod;
		logic [WORD_W-1:0] reqWord;
		logic reqCache;
		logic seq;
		logic hit;
		logic [STALL_W-1:0] full;
		logic [MOD_W-1:0] aMod;
		logic [WORD_W-1:0] aWord;
		logic [MODULES-1:0] readers;
		logic oscRise;
		reqMod = link.rdAddr[MOD_W+WORD_W-1:WORD_W];
		reqWord = link.rdAddr[WORD_W-1:0];
		reqCache = link.rdAddr[ADDR_W-1];
		aMod = s.curAddr[MOD_W+WORD_W-1:WORD_W];
		aWord = s.curAddr[WORD_W-1:0];
		readers = '0;
		oscRise = crystalInput & ~s.oscPrev;
		full = STALL_W'(link.flashWaitCount) + STALL_W'(link.flashWaitExtension);
		seq = s.lastValid && !reqCache && reqMod == s.lastModule && reqWord == s.lastWord + 4'h1;
		hit = reqCache && s.cacheValid && s.cacheTag == link.rdAddr[MOD_W+WORD_W-1:0];
		n = s;
		n.rdValid = 1'b0;
		n.peAccept = 1'b0;
		n.peReject = 1'b0;
		n.peDone = 1'b0;

		// Prefetch runs ahead after each read without error; a sequential read waits only for what is left
		if (s.prefetch != '0) begin
			n.prefetch = s.prefetch - 4'h1;
		end

		// Read path
		unique case (s.rd)
			RD_IDLE: begin
				if (link.rdReq) begin
					n.rd = RD_WAIT;
					n.curAddr = link.rdAddr;
					if (hit) begin
						n.stall = '0;
					end else if (reqCache) begin
						n.stall = full + 4'h1;
					end else if (seq) begin
						n.stall = s.prefetch;
					end else begin
						n.stall = full;
					end
				end
			end
			RD_WAIT: begin
				if (s.stall != '0) begin
					n.stall = s.stall - 4'h1;
				end else begin
					n.rd = RD_IDLE;
					n.rdValid = 1'b1;
					// A module under program/erase cannot deliver data
					if (aMod >= MOD_W'(MODULES) || s.peBusy[aMod]) begin
						n.rdError = 1'b1;
						n.rdData = '0;
					end else begin
						n.rdError = 1'b0;
						if (s.curAddr[ADDR_W-1] && s.cacheValid && s.cacheTag == s.curAddr[MOD_W+WORD_W-1:0]) begin
							n.rdData = s.cacheData;
						end else begin
							n.rdData = s.mem[aMod][aWord];
						end
						if (s.curAddr[ADDR_W-1]) begin
							n.cacheValid = 1'b1;
							n.cacheTag = s.curAddr[MOD_W+WORD_W-1:0];
							n.cacheData = s.mem[aMod][aWord];
						end
						n.lastValid = 1'b1;
						n.lastModule = aMod;
						n.lastWord = aWord;
						n.prefetch = full;
					end
				end
			end
		endcase

		// Modules that supply data now: the last one read and the one being read
		if (s.lastValid && s.lastModule < MOD_W'(MODULES)) begin
			readers[s.lastModule] = 1'b1;
		end
		if (s.rd == RD_WAIT && aMod < MOD_W'(MODULES)) begin
			readers[aMod] = 1'b1;
		end

		// Program/erase sequencing
		if (s.peBusy != '0) begin
			if (s.peCnt != '0) begin
				n.peCnt = s.peCnt - 21'h1;
			end else begin
				for (int m = 0; m < MODULES; m++) begin
					if (s.peBusy[m]) begin
						if (s.peErase) begin
							n.mem[m] = '1;
						end else begin
							// Programming only clears bits, as in a real cell
							n.mem[m][s.peWord] = s.mem[m][s.peWord] & s.peData;
						end
					end
				end
				if (s.cacheTag[MOD_W+WORD_W-1:WORD_W] < MOD_W'(MODULES) &&
					s.peBusy[s.cacheTag[MOD_W+WORD_W-1:WORD_W]]) begin
					n.cacheValid = 1'b0;
				end
				n.peBusy = '0;
				n.peDone = 1'b1;
			end
		end
		if (link.peStart) begin
			// module four is free unless it is the reader
			if (s.peBusy != '0 || link.peMask == '0 || (link.peMask & readers) != '0) begin
				n.peReject = 1'b1;
			end else begin
				n.peAccept = 1'b1;
				n.peBusy = link.peMask;
				n.peErase = link.peErase;
				n.peWord = link.peWord;
				n.peData = link.peData;
				n.peCnt = link.peErase ? PE_CNT_W'(ERASE_RUN + PE_OVERHEAD_CYCLES - 1)
					: PE_CNT_W'(PROG_RUN + PE_OVERHEAD_CYCLES - 1);
			end
		end

		// System clock generation from sampled clock inputs
		n.oscPrev = crystalInput;
		if (oscRise) begin
			n.divCnt = (s.divCnt >= link.outputDividerValue) ? '0 : s.divCnt + 10'h1;
		end
		unique case (link.clockSourceSelect)
			CLKSRC_DIRECT: begin
				n.sysClk = directClockInput;
			end
			CLKSRC_PRESCALE: begin
				if (!link.vcoBypass) begin
					n.sysClk = 1'b0;
				end else if (link.outputDividerValue == '0) begin
					n.sysClk = crystalInput;
				// high for the first half of the period
				end else begin
					n.sysClk = n.divCnt <= (link.outputDividerValue >> 1);
				end
			end
			// Wakeup and loop sources are not generated here
			default: begin
				n.sysClk = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.mem <= '1;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state
	assign link.rdValid = s.rdValid;
	assign link.rdError = s.rdError;
	assign link.rdData = s.rdData;
	assign link.peAccept = s.peAccept;
	assign link.peReject = s.peReject;
	assign link.peDone = s.peDone;
	assign link.peBusy = s.peBusy;
	assign sysClockOut = s.sysClk;
	assign moduleBusy = s.peBusy;
endmodule : fass_device
`default_nettype wire

/* verilog/fass_host.sv */
// Fetch/command end: AXI4-Lite registers that drive reads, program/erase and clock setup
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fass_host
	import fass_pkg::*;
#(
	parameter int SYS_MHZ = 200
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	fass_if.host link
);
	typedef struct packed {
		logic awHeld;
		logic [AXI_ADDR_W-1:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [WAIT_W-1:0] waitCount;
		logic [EXT_W-1:0] waitExt;
		logic safeFlashAfterReset;
		logic [1:0] clock_source_select;
		logic vcoBypass;
		logic [DIV_W-1:0] divider;
		logic [DATA_W-1:0] peData;
		logic peStart;
		logic peErase;
		logic [MODULES-1:0] peMask;
		logic [WORD_W-1:0] peWord;
		logic pePending;
		logic peRejected;
		logic peDoneFlag;
		logic rdReq;
		logic [ADDR_W-1:0] rdAddr;
		logic rdPending;
		logic rdDone;
		logic rdErr;
		logic [DATA_W-1:0] rdDataReg;
		logic [MODULES-1:0] readMask;
	} fass_host_state_t;

	localparam logic [WAIT_W-1:0] MIN_WAIT = fass_min_wait(SYS_MHZ);
	localparam logic [EXT_W-1:0] MIN_EXT = fass_min_ext(SYS_MHZ);

	fass_host_state_t s;
	fass_host_state_t n;

	function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
		return a <= REG_STATUS && a[1:0] == 2'h0;
	endfunction : mapped

	// Register image as software sees it
	function automatic logic [31:0] image(input logic [AXI_ADDR_W-1:0] a, input fass_host_state_t st,
		input logic [MODULES-1:0] busy);
		logic [31:0] v;
		v = '0;
		case (a)
			REG_BUS_CTRL: v = {26'h0, st.waitExt, 1'b0, st.waitCount};
			REG_STARTUP: v = {31'h0, st.safeFlashAfterReset};
			REG_CLK_CTRL: v = {6'h0, st.divider, 13'h0, st.vcoBypass, st.clock_source_select};
			REG_PE_CMD: v = {16'h0, st.peWord, 3'h0, st.peErase, 3'h0, st.peMask};
			REG_PE_DATA: v = st.peData;
			REG_READ_ADDR: v = {24'h0, st.rdAddr};
			REG_READ_DATA: v = st.rdDataReg;
			REG_STATUS: v = {18'h0, st.pePending, st.rdPending, st.peDoneFlag, st.peRejected,
				st.rdErr, st.rdDone, 3'h0, busy};
			default: v = '0;
		endcase
		return v;
	endfunction : image

	// Next state
	always_comb begin
		logic [31:0] bm;
		logic [31:0] m;
		logic [2:0] limit;
		bm = {{8{s.wStrb[3]}}, {8{s.wStrb[2]}}, {8{s.wStrb[1]}}, {8{s.wStrb[0]}}};
		m = (image(s.awAddr, s, link.peBusy) & ~bm) | (s.wData & bm);
		// one module when reads are spread
		limit = (fass_ones(s.readMask) > 3'h1) ? PAR_PE_CONTENDED : PAR_PE_MAX;
		n = s;
		n.rdReq = 1'b0;
		n.peStart = 1'b0;

		// Read channel: one outstanding, answered the cycle after it is taken
		if (s.rValid && rready) begin
			n.rValid = 1'b0;
		end
		if (arvalid && !s.rValid) begin
			n.rValid = 1'b1;
			n.rData = image(araddr, s, link.peBusy);
			n.rResp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// Write channels are taken independently; the response follows both
		if (awvalid && !s.awHeld && !s.bValid) begin
			n.awHeld = 1'b1;
			n.awAddr = awaddr;
		end
		if (wvalid && !s.wHeld && !s.bValid) begin
			n.wHeld = 1'b1;
			n.wData = wdata;
			n.wStrb = wstrb;
		end
		if (s.bValid && bready) begin
			n.bValid = 1'b0;
		end
		if (s.awHeld && s.wHeld) begin
			n.awHeld = 1'b0;
			n.wHeld = 1'b0;
			n.bValid = 1'b1;
			n.bResp = mapped(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
			case (s.awAddr)
				REG_BUS_CTRL: begin
					n.waitCount = m[WAIT_W-1:0];
					n.waitExt = m[EXT_POS+EXT_W-1:EXT_POS];
				end
				REG_STARTUP: begin
					n.safeFlashAfterReset = m[0];
					if (m[APP_RESET_POS]) begin
						n.waitCount = m[0] ? WAIT_SAFE : WAIT_RST;
						n.waitExt = m[0] ? EXT_SAFE : EXT_RST;
					end
				end
				REG_CLK_CTRL: begin
					n.clock_source_select = m[1:0];
					n.vcoBypass = m[VCO_BYPASS_POS];
					n.divider = m[DIV_POS+DIV_W-1:DIV_POS];
				end
				REG_PE_DATA: n.peData = m;
				REG_PE_CMD: begin
					n.peMask = m[MODULES-1:0];
					n.peErase = m[PE_ERASE_POS];
					n.peWord = m[PE_WORD_POS+WORD_W-1:PE_WORD_POS];
					if (m[PE_GO_POS]) begin
						if (s.pePending || link.peBusy != '0 || m[MODULES-1:0] == '0 ||
							fass_ones(m[MODULES-1:0]) > limit || (m[MODULES-1:0] & s.readMask) != '0) begin
							n.peRejected = 1'b1;
						end else begin
							n.peStart = 1'b1;
							n.pePending = 1'b1;
						end
					end
				end
				REG_READ_ADDR: begin
					// A read while one is pending is ignored
					if (!s.rdPending) begin
						n.rdReq = 1'b1;
						n.rdAddr = m[ADDR_W-1:0];
						n.rdPending = 1'b1;
					end
				end
				REG_STATUS: begin
					// Write one to clear; device events below win over the clear
					if (s.wData[ST_RD_DONE] && bm[ST_RD_DONE]) n.rdDone = 1'b0;
					if (s.wData[ST_RD_ERR] && bm[ST_RD_ERR]) n.rdErr = 1'b0;
					if (s.wData[ST_PE_REJ] && bm[ST_PE_REJ]) n.peRejected = 1'b0;
					if (s.wData[ST_PE_DONE] && bm[ST_PE_DONE]) n.peDoneFlag = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// Device answers
		if (link.peDone) begin
			n.peDoneFlag = 1'b1;
			n.readMask = '0;
		end
		if (link.rdValid) begin
			n.rdPending = 1'b0;
			n.rdDone = 1'b1;
			n.rdErr = link.rdError;
			n.rdDataReg = link.rdData;
			if (!link.rdError) begin
				n.readMask[s.rdAddr[MOD_W+WORD_W-1:WORD_W]] = 1'b1;
			end
		end
		if (link.peAccept) begin
			n.pePending = 1'b0;
		end
		if (link.peReject) begin
			n.pePending = 1'b0;
			n.peRejected = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.waitCount <= WAIT_RST;
			s.waitExt <= EXT_RST;
		end else begin
			s <= n;
		end
	end

	// Handshakes and register outputs
	assign awready = !s.awHeld && !s.bValid;
	assign wready = !s.wHeld && !s.bValid;
	assign bvalid = s.bValid;
	assign bresp = s.bResp;
	assign arready = !s.rValid;
	assign rvalid = s.rValid;
	assign rdata = s.rData;
	assign rresp = s.rResp;
	assign link.flashWaitCount = (s.waitCount < MIN_WAIT) ? MIN_WAIT : s.waitCount;
	assign link.flashWaitExtension = (s.waitExt < MIN_EXT) ? MIN_EXT : s.waitExt;
	assign link.rdReq = s.rdReq;
	assign link.rdAddr = s.rdAddr;
	assign link.peStart = s.peStart;
	assign link.peErase = s.peErase;
	assign link.peMask = s.peMask;
	assign link.peWord = s.peWord;
	assign link.peData = s.peData;
	assign link.clockSourceSelect = s.clock_source_select;
	assign link.vcoBypass = s.vcoBypass;
	assign link.outputDividerValue = s.divider;
endmodule : fass_host
`default_nettype wire

/* verif/fass_properties.sv */
// Link-level timing and refusal checks between the two ends
`timescale 1ns/1ps
`default_nettype none
module fass_properties
	import fass_pkg::*;
#(
	parameter int PROG_RUN = PROG_CYCLES,
	parameter int ERASE_RUN = ERASE_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rdReq,
	input wire logic [ADDR_W-1:0] rdAddr,
	input wire logic rdValid,
	input wire logic rdError,
	input wire logic [WAIT_W-1:0] flashWaitCount,
	input wire logic [EXT_W-1:0] flashWaitExtension,
	input wire logic peStart,
	input wire logic peErase,
	input wire logic [MODULES-1:0] peMask,
	input wire logic peAccept,
	input wire logic peReject,
	input wire logic peDone,
	input wire logic [MODULES-1:0] peBusy
);
	logic [ADDR_W-1:0] lastAddr, cacheAddr, rqAddr;
	logic lastOk, hitOk, rqBad, peLong;
	logic [1:0] rqKind;
	logic [4:0] rqSum, lat;
	logic [2:0] rqMod;
	int peCnt, peRun;

	assign rqMod = rdAddr[6:4];
	assign peRun = peLong ? ERASE_RUN : PROG_RUN;

	// Classify each read when taken: 0 random, 1 miss, 2 hit, 3 sequential
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{lastAddr, cacheAddr, rqAddr} <= '0;
			{lastOk, hitOk, rqBad, peLong, rqKind, rqSum, lat} <= '0;
			peCnt <= 0;
		end else begin
			lat <= rdReq ? 5'h0 : lat + 5'h1;
			peCnt <= peAccept ? 0 : peCnt + 1;
			if (peStart) peLong <= peErase;
			if (rdReq) begin
				rqAddr <= rdAddr;
				rqSum <= 5'(flashWaitCount) + 5'(flashWaitExtension);
				rqBad <= (rqMod >= 3'h5) || ((peBusy & (5'h1 << rqMod)) != 5'h0);
				if (rdAddr[7]) rqKind <= (hitOk && rdAddr == cacheAddr) ? 2'h2 : 2'h1;
				else if (lastOk && rqMod == lastAddr[6:4] && rdAddr[3:0] == lastAddr[3:0] + 4'h1) rqKind <= 2'h3;
				else rqKind <= 2'h0;
			end
			// Only good answers count as the module supplying code
			if (rdValid && !rdError) begin
				lastOk <= 1'b1;
				lastAddr <= rqAddr;
				hitOk <= hitOk | rqAddr[7];
				if (rqAddr[7]) cacheAddr <= rqAddr;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_random_stall: assert property (rdValid && !rqBad && rqKind == 2'h0 |-> lat == rqSum + 5'h1)
		else $error("random read stall wrong");
	a_miss_stall: assert property (rdValid && !rqBad && rqKind == 2'h1 |-> lat == rqSum + 5'h2)
		else $error("cache miss stall wrong");
	a_hit_stall: assert property (rdValid && !rqBad && rqKind == 2'h2 |-> lat == 5'h1)
		else $error("cache hit stall wrong");
	a_seq_bound: assert property (rdValid && !rqBad && rqKind == 2'h3 |-> lat <= rqSum + 5'h1)
		else $error("sequential read too slow");
	a_read_bound: assert property (rdReq |-> ##[1:16] rdValid)
		else $error("read never answered");
	a_refuse_read: assert property (rdValid |-> rdError == rqBad)
		else $error("read error flag wrong");
	a_pe_guard: assert property (peStart && lastOk && (peMask & (5'h1 << lastAddr[6:4])) != 5'h0 |=> peReject)
		else $error("change of supplying module allowed");
	a_pe_time: assert property (peDone |-> peCnt >= peRun + 2 && peCnt <= peRun + 6)
		else $error("program or erase length wrong");
	a_wait_floor: assert property (flashWaitCount >= WAIT_SAFE && flashWaitExtension >= EXT_SAFE)
		else $error("wait setting below floor");

	// Main scenarios reached
	c_cache_hit: cover property (rdValid && rqKind == 2'h2);
	c_pe_done: cover property (peDone);
	c_pe_reject: cover property (peReject);
endmodule : fass_properties
`default_nettype wire

/* verif/fass_tb.sv */
// Self-checking bench joining both ends over the shared link
`timescale 1ns/1ps
`default_nettype none
module fass_tb
	import fass_pkg::*;
();
	localparam int PRUN = 20;
	localparam int ERUN = 30;
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, sysClk;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, v;
	logic dirIn = 1'b0, xtalIn = 1'b0;
	logic [MODULES-1:0] modBusy;
	int badCount = 0, cmpCount = 0, cyc = 0;

	fass_if link();
	fass_host u_fass_host (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link(link));
	fass_device #(.PROG_RUN(PRUN), .ERASE_RUN(ERUN)) u_fass_device (.clk, .resetn, .link(link),
		.directClockInput(dirIn), .crystalInput(xtalIn), .sysClockOut(sysClk), .moduleBusy(modBusy));
	fass_properties #(.PROG_RUN(PRUN), .ERASE_RUN(ERUN)) u_fass_properties (.clk, .resetn, .rdReq(link.rdReq),
		.rdAddr(link.rdAddr), .rdValid(link.rdValid), .rdError(link.rdError), .flashWaitCount(link.flashWaitCount),
		.flashWaitExtension(link.flashWaitExtension), .peStart(link.peStart), .peErase(link.peErase),
		.peMask(link.peMask), .peAccept(link.peAccept), .peReject(link.peReject), .peDone(link.peDone),
		.peBusy(link.peBusy));

	// 200 MHz system clock
	always #2.5 clk = ~clk;

	// Clock sources and hang guard; uneven direct pattern exposes a stuck path
	always @(posedge clk) begin
		cyc <= cyc + 1;
		dirIn <= cyc[0] ^ cyc[2];
		xtalIn <= ~xtalIn;
		if (cyc == LIMIT) begin
			badCount++;
			wrapUp();
		end
	end

	task automatic wrapUp();
		$display("comparisons %0d mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrapUp

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			badCount++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// AXI write; each channel dropped once taken, response awaited
	task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	// AXI read into v
	task automatic rd(input logic [AXI_ADDR_W-1:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rdChk(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] exp);
		rd(a);
		chk(v, exp);
	endtask : rdChk

	// Polling is cut short only by the hang guard
	task automatic waitStat(input int b);
		do rd(REG_STATUS); while (v[b] !== 1'b1);
	endtask : waitStat

	// Link read via registers; error flag and data judged, flags cleared
	task automatic flashRead(input logic [7:0] a, input logic [31:0] d, input logic e);
		wr(REG_READ_ADDR, {24'h0, a});
		waitStat(ST_RD_DONE);
		chk(v[ST_RD_ERR], e);
		rdChk(REG_READ_DATA, d);
		wr(REG_STATUS, 32'h0000_0f00);
	endtask : flashRead

	// System clock must repeat the chosen source one cycle late
	task automatic follow(input logic x);
		logic p;
		repeat (8) @(posedge clk);
		p = x ? xtalIn : dirIn;
		repeat (16) begin
			@(posedge clk);
			chk(sysClk, p);
			p = x ? xtalIn : dirIn;
		end
	endtask : follow

	// Rising edges of the system clock over 64 cycles
	task automatic rises(input int n);
		int k;
		logic p;
		k = 0;
		repeat (16) @(posedge clk);
		p = sysClk;
		repeat (64) begin
			@(posedge clk);
			if (sysClk === 1'b1 && p === 1'b0) k++;
			p = sysClk;
		end
		chk(k, n);
	endtask : rises

	task automatic tBoot();
		rdChk(REG_STATUS, 32'h0);
		rdChk(REG_BUS_CTRL, 32'h1);
		chk(link.flashWaitCount, 3'h4);
		chk(link.flashWaitExtension, 2'h1);
		rd(12'h020);
		chk(resp, RESP_SLVERR);
		wr(REG_STARTUP, 32'h3);
		chk(resp, RESP_OKAY);
		rdChk(REG_BUS_CTRL, 32'h14);
		wr(REG_BUS_CTRL, 32'h25);
		chk(link.flashWaitCount, 3'h5);
	endtask : tBoot

	task automatic tReads();
		flashRead(8'h00, 32'hffff_ffff, 1'b0);
		flashRead(8'h01, 32'hffff_ffff, 1'b0);
		flashRead(8'h92, 32'hffff_ffff, 1'b0);
		flashRead(8'h92, 32'hffff_ffff, 1'b0);
		flashRead(8'h50, 32'h0, 1'b1);
		flashRead(8'h03, 32'hffff_ffff, 1'b0);
	endtask : tReads

	// Spare module changed while module 0 supplies code, then module 0 refused
	task automatic tProgram();
		wr(REG_PE_DATA, 32'h0000_a5c3);
		wr(REG_PE_CMD, 32'h8000_3010);
		waitStat(ST_PE_DONE);
		chk(v[ST_PE_REJ], 1'b0);
		wr(REG_STATUS, 32'h0000_0f00);
		wr(REG_PE_CMD, 32'h8000_3001);
		repeat (4) @(posedge clk);
		rd(REG_STATUS);
		chk(v[ST_PE_REJ], 1'b1);
		wr(REG_STATUS, 32'h0000_0f00);
		flashRead(8'h43, 32'h0000_a5c3, 1'b0);
	endtask : tProgram

	// Four modules at once with one read module, then two refused after spread reads
	task automatic tErase();
		wr(REG_PE_CMD, 32'h8000_010f);
		repeat (4) @(posedge clk);
		chk(modBusy, 5'h0f);
		flashRead(8'h00, 32'h0, 1'b1);
		waitStat(ST_PE_DONE);
		wr(REG_STATUS, 32'h0000_0f00);
		flashRead(8'h10, 32'hffff_ffff, 1'b0);
		flashRead(8'h20, 32'hffff_ffff, 1'b0);
		wr(REG_PE_CMD, 32'h8000_0118);
		repeat (4) @(posedge clk);
		rd(REG_STATUS);
		chk(v[ST_PE_REJ], 1'b1);
	endtask : tErase

	task automatic tClock();
		wr(REG_CLK_CTRL, 32'h3);
		follow(1'b0);
		wr(REG_CLK_CTRL, 32'h6);
		follow(1'b1);
		wr(REG_CLK_CTRL, 32'h0003_0006);
		rises(8);
		wr(REG_CLK_CTRL, 32'h2);
		rises(0);
	endtask : tClock

	// Reset for four cycles, then the scenarios in order
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		tBoot();
		tReads();
		tProgram();
		tErase();
		tClock();
		wrapUp();
	end
endmodule : fass_tb
`default_nettype wire
